/* logic/port_select_pkg.sv */
package port_select_pkg;

  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PA_W   = 4;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_XFER    = 8'h08;
  localparam logic [7:0] OFS_RXDATA  = 8'h0c;
  localparam logic [7:0] OFS_PRIMARY = 8'h14;

  // Transfer register fields
  localparam int unsigned XF_DATA_LSB = 0;
  localparam int unsigned XF_PA_LSB   = 16;
  localparam int unsigned XF_HASPA    = 20;
  localparam int unsigned XF_INPUT    = 21;

  // Control register fields
  localparam int unsigned CT_HSOUT_LSB = 0;

  localparam logic [PA_W-1:0] PRIMARY_RST = 4'h0;
  localparam int unsigned     FIFO_DEPTH  = 16;
  localparam int unsigned     FIFO_WIDTH  = 22;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    KIND_BIDIR_SMALL = 2'b00,
    KIND_SPLIT       = 2'b01,
    KIND_OUT_ONLY    = 2'b10,
    KIND_BIDIR_LARGE = 2'b11
  } port_kind_t;

endpackage

/* logic/sync_fifo.sv */
`timescale 1ns/1ps
module sync_fifo #(
  parameter int unsigned WIDTH = 22,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fifo_state_t;

  fifo_state_t      st_r;
  fifo_state_t      st_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      fill;

  assign fill      = st_r.wp - st_r.rp;
  assign in_ready  = fill != (AW + 1)'(DEPTH);
  assign out_valid = fill != '0;
  assign out_data  = mem[st_r.rp[AW-1:0]];

  always_comb begin
    st_nxt = st_r;
    if (in_valid && in_ready) begin
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (out_valid && out_ready) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
    if (in_valid && in_ready) begin
      mem[st_r.wp[AW-1:0]] <= in_data;
    end
  end
endmodule

/* logic/parallel_port_address_select.sv */
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
// What this block does
// - Addresses 00 and 01 give bidirectional small-drive ports A and B, each with its own handshake pair and direction line.
// - Address 02 reads port A and drives port C on the A pair; address 03 reads port B and drives port D on the B pair.
// - Addresses 04 and 05 give output-only ports C and D on general control/sense zero and one, with no direction line.
// - Address 06 joins ports A and C as one large-drive bidirectional port on the A pair, and 07 joins B and D on the B pair.
// - The direction line of the active bidirectional port is low while outputting and high while inputting.
// - The primary address carried with each transfer request selects its port type.
// - A request with no primary address reuses the one most recently given.
// - With no address given since reset the default switch setting is used.
// - Writing the primary register sets the current primary address directly.
// - The default switches may pick any byte-wide address and it is loaded at every reset.
// - Byte-wide use offers at most four ports: two bidirectional small-drive and two output-only.
// - Large-drive bidirectional use leaves only two byte ports, as each takes one bidirectional and one output port.
// - Word-wide use allows two ports only as one output-only plus one small-drive bidirectional, otherwise one.
// - Flag lines come from the peripheral, control lines go to it, and output-only ports sense the status line instead.
// - Word addresses 08 to 15 mirror the byte map with low bits on A or C and high bits on B or D; odd ones use the B pair or control one.
module parallel_port_address_select
  import port_select_pkg::*;
(
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  input  wire logic [port_select_pkg::PA_W-1:0]  default_switch,
  input  wire logic [port_select_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [port_select_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [port_select_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [port_select_pkg::DATA_W-1:0]     s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  input  wire logic [7:0]                        port_a_in,
  output logic [7:0]                             port_a_out,
  output logic [7:0]                             port_a_oe,
  input  wire logic [7:0]                        port_b_in,
  output logic [7:0]                             port_b_out,
  output logic [7:0]                             port_b_oe,
  output logic [7:0]                             port_c_out,
  output logic [7:0]                             port_c_oe,
  output logic [7:0]                             port_d_out,
  output logic [7:0]                             port_d_oe,
  output logic                                   port_a_handshake_out,
  input  wire logic                              port_a_handshake_in,
  output logic                                   port_b_handshake_out,
  input  wire logic                              port_b_handshake_in,
  output logic                                   general_control_zero,
  input  wire logic                              general_sense_zero,
  output logic                                   general_control_one,
  input  wire logic                              general_sense_one,
  output logic                                   port_a_direction_indicator,
  output logic                                   port_b_direction_indicator
);
  import port_select_pkg::*;

  typedef struct packed {
    logic            aw_held;
    logic [7:0]      aw_ofs;
    logic            w_held;
    logic [31:0]     w_data;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
    logic [PA_W-1:0] primary;
    logic            given;
    logic [3:0]      hs_out;
    logic [15:0]     out_data;
    logic [15:0]     rx_data;
    logic            inputting;
    logic            driving;
    logic [2:0]      sync_a1;
    logic [2:0]      sync_a2;
    logic [2:0]      sync_b1;
    logic [1:0]      flag_a;
    logic            flag_b;
    logic [3:0]      sense;
    logic [15:0]     pin1;
    logic [15:0]     pin2;
    logic [15:0]     pin3;
    logic [15:0]     pin_stable;
  } state_t;

  state_t                  st_r;
  state_t                  st_nxt;
  logic                    boot_r;
  logic [FIFO_WIDTH-1:0]   fifo_out;
  logic                    fifo_valid;
  logic                    fifo_in_ready;
  logic                    fifo_pop;
  logic                    fifo_push;
  logic [PA_W-1:0]         cur_pa;
  port_kind_t              kind;
  logic                    odd;
  logic                    wide;

  // Bits 2:1 pick the port kind in both the byte and word maps
  function automatic port_kind_t kind_of(input logic [PA_W-1:0] pa);
    kind_of = port_kind_t'(pa[2:1]);
  endfunction

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw, input logic [3:0] be,
                                       input int unsigned lane);
    merge = be[lane] ? nw : old;
  endfunction

  // Requests queue behind the bus so software can post a burst of writes
  sync_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) xfer_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_data   (st_r.w_data[FIFO_WIDTH-1:0]),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // One request applied per cycle; the peripheral handshake itself is software driven
  assign fifo_pop = fifo_valid;
  assign fifo_push = st_r.aw_held && st_r.w_held && !st_r.bvalid
                     && st_r.aw_ofs == OFS_XFER && fifo_in_ready;

  assign cur_pa = st_r.primary;
  assign kind   = kind_of(cur_pa);
  assign odd    = cur_pa[0];
  assign wide   = cur_pa[3];

  always_comb begin
    logic            wr_go;
    logic            wr_ok;
    logic [PA_W-1:0] req_pa;
    wr_go  = 1'b0;
    wr_ok  = 1'b1;
    req_pa = '0;
    st_nxt = st_r;

    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_ofs  = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_held = 1'b1;
      for (int i = 0; i < 4; i++) begin
        st_nxt.w_data[i*8 +: 8] = merge(8'h00, s_axi_wdata[i*8 +: 8], s_axi_wstrb, i);
      end
    end

    // Transfer writes wait for FIFO room, which stalls the write response
    if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
      if (st_r.aw_ofs != OFS_XFER || fifo_in_ready) begin
        wr_go = 1'b1;
      end
    end

    if (wr_go) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      unique case (st_r.aw_ofs)
        OFS_CTRL: begin
          st_nxt.hs_out = st_r.w_data[CT_HSOUT_LSB +: 4];
        end
        OFS_PRIMARY: begin
          st_nxt.primary = st_r.w_data[PA_W-1:0];
          st_nxt.given   = 1'b1;
        end
        OFS_XFER: begin
        end
        default: begin
          wr_ok = 1'b0;
        end
      endcase
      st_nxt.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = RESP_OKAY;
      unique case (s_axi_araddr[7:0])
        OFS_CTRL:    st_nxt.rdata = {28'h0000000, st_r.hs_out};
        OFS_STATUS:  st_nxt.rdata = {22'h000000, st_r.given, st_r.inputting, st_r.sense, PA_W'(cur_pa)};
        OFS_RXDATA:  st_nxt.rdata = {16'h0000, st_r.rx_data};
        OFS_PRIMARY: st_nxt.rdata = {28'h0000000, st_r.primary};
        default: begin
          st_nxt.rdata = 32'h00000000;
          st_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    if (fifo_valid) begin
      req_pa = fifo_out[XF_PA_LSB +: PA_W];
      if (fifo_out[XF_HASPA]) begin
        st_nxt.primary = req_pa;
        st_nxt.given   = 1'b1;
      end
      st_nxt.inputting = fifo_out[XF_INPUT];
      st_nxt.driving   = !fifo_out[XF_INPUT];
      if (!fifo_out[XF_INPUT]) begin
        st_nxt.out_data = fifo_out[XF_DATA_LSB +: 16];
      end
    end
    // Input follows the stable pins every cycle while inputting is set, from the cycle after the request, so early samples can still catch the port driving
    if (st_r.inputting) begin
      st_nxt.rx_data = st_r.pin_stable;
    end

    // Pins cross in through three stages; a change counts when stages two and three agree
    st_nxt.pin1 = {port_b_in, port_a_in};
    st_nxt.pin2 = st_r.pin1;
    st_nxt.pin3 = st_r.pin2;
    if (st_r.pin3 == st_r.pin2) begin
      st_nxt.pin_stable = st_r.pin3;
    end
    st_nxt.sync_a1 = {general_sense_zero, port_a_handshake_in, general_sense_one};
    st_nxt.sync_a2 = st_r.sync_a1;
    st_nxt.sync_b1 = st_r.sync_a2;
    for (int i = 0; i < 3; i++) begin
      if (st_r.sync_a2[i] == st_r.sync_b1[i]) begin
        st_nxt.sense[i] = st_r.sync_b1[i];
      end
    end
    st_nxt.flag_a = {st_r.flag_a[0], port_b_handshake_in};
    st_nxt.flag_b = st_r.flag_a[1];
    if (st_r.flag_a[1] == st_r.flag_b) begin
      st_nxt.sense[3] = st_r.flag_b;
    end
  end

  assign s_axi_awready = !st_r.aw_held && !st_r.bvalid;
  assign s_axi_wready  = !st_r.w_held && !st_r.bvalid;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r   <= '0;
      boot_r <= 1'b1;
    end else begin
      st_r   <= st_nxt;
      boot_r <= 1'b0;
      if (boot_r) begin
        st_r.primary <= {1'b0, default_switch[2:0]};
      end
    end
  end

  // Pin steering; unselected roles idle low with enables off, except the direction lines, which idle high
  always_comb begin
    logic       dir_out;
    logic [7:0] lo;
    logic [7:0] hi;
    dir_out = st_r.driving;
    lo = st_r.out_data[7:0];
    hi = wide ? st_r.out_data[15:8] : st_r.out_data[7:0];
    port_a_out = 8'h00;
    port_a_oe  = 8'h00;
    port_b_out = 8'h00;
    port_b_oe  = 8'h00;
    port_c_out = 8'h00;
    port_c_oe  = 8'h00;
    port_d_out = 8'h00;
    port_d_oe  = 8'h00;
    port_a_handshake_out = 1'b0;
    port_b_handshake_out = 1'b0;
    general_control_zero = 1'b0;
    general_control_one  = 1'b0;
    port_a_direction_indicator = 1'b1;
    port_b_direction_indicator = 1'b1;
    unique case (kind)
      KIND_BIDIR_SMALL: begin
        if (wide || !odd) begin
          port_a_out = lo;
          port_a_oe  = {8{dir_out}};
        end
        if (wide || odd) begin
          port_b_out = hi;
          port_b_oe  = {8{dir_out}};
        end
      end
      KIND_SPLIT: begin
        if (wide || !odd) begin
          port_c_out = lo;
          port_c_oe  = {8{dir_out}};
        end
        if (wide || odd) begin
          port_d_out = hi;
          port_d_oe  = {8{dir_out}};
        end
      end
      KIND_OUT_ONLY: begin
        if (wide || !odd) begin
          port_c_out = lo;
          port_c_oe  = {8{dir_out}};
        end
        if (wide || odd) begin
          port_d_out = hi;
          port_d_oe  = {8{dir_out}};
        end
      end
      KIND_BIDIR_LARGE: begin
        if (wide || !odd) begin
          port_c_oe = dir_out ? ~lo : 8'h00;
        end
        if (wide || odd) begin
          port_d_oe = dir_out ? ~hi : 8'h00;
        end
      end
    endcase
    if (kind == KIND_OUT_ONLY) begin
      general_control_zero = !odd && st_r.hs_out[2];
      general_control_one  = odd && st_r.hs_out[3];
    end else if (odd) begin
      port_b_handshake_out = st_r.hs_out[1];
      port_b_direction_indicator = !dir_out;
    end else begin
      port_a_handshake_out = st_r.hs_out[0];
      port_a_direction_indicator = !dir_out;
    end
  end

  // Port counts follow from one address driving one set of roles at a time
endmodule

/* verification/port_select_props.sv */
`timescale 1ns/1ps
module port_select_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [7:0]  port_a_oe,
  input wire logic [7:0]  port_b_oe,
  input wire logic        port_a_direction_indicator,
  input wire logic        port_b_direction_indicator
);
  logic aw_r;
  logic w_r;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Write halves seen, cleared once the answer is taken
  always_ff @(posedge aclk) begin
    if (!aresetn || (s_axi_bvalid && s_axi_bready)) begin
      aw_r <= 1'b0;
      w_r  <= 1'b0;
    end else begin
      aw_r <= aw_r | (s_axi_awvalid & s_axi_awready);
      w_r  <= w_r | (s_axi_wvalid & s_axi_wready);
    end
  end
  chk_reset_idle: assert property (
    $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && port_a_oe == 8'h00 && port_b_oe == 8'h00
      && port_a_direction_indicator && port_b_direction_indicator) else $error("not idle after reset");
  chk_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  chk_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  chk_read_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  chk_write_latency: assert property (
    aw_r && w_r |-> ##[0:24] s_axi_bvalid) else $error("write answer late");
  chk_write_single: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("extra write answer");
  chk_one_direction: assert property (
    port_a_direction_indicator || port_b_direction_indicator) else $error("both pairs outputting");
  chk_a_drive_dir: assert property (
    port_a_oe != 8'h00 |-> !(port_a_direction_indicator && port_b_direction_indicator)) else $error("a driven");
  chk_b_drive_dir: assert property (
    port_b_oe != 8'h00 |-> !(port_a_direction_indicator && port_b_direction_indicator)) else $error("b driven");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (!port_a_direction_indicator ##1 port_a_direction_indicator);
endmodule

/* verification/periph_model.sv */
`timescale 1ns/1ps
module periph_model (
  input  wire logic [7:0]  port_a_out,
  input  wire logic [7:0]  port_a_oe,
  input  wire logic [7:0]  port_b_out,
  input  wire logic [7:0]  port_b_oe,
  input  wire logic        port_a_direction_indicator,
  input  wire logic        port_b_direction_indicator,
  input  wire logic [15:0] drive_word,
  input  wire logic [3:0]  flag_set,
  output logic [7:0]       port_a_in,
  output logic [7:0]       port_b_in,
  output logic             port_a_handshake_in,
  output logic             port_b_handshake_in,
  output logic             general_sense_zero,
  output logic             general_sense_one
);
  logic talk;
  assign talk = port_a_direction_indicator & port_b_direction_indicator;
  // Released lines carry drive_word while both direction lines are high, else rise to the pull-up level; never hold the last value
  assign port_a_in = (port_a_oe & port_a_out) | (~port_a_oe & (talk ? drive_word[7:0] : 8'hff));
  assign port_b_in = (port_b_oe & port_b_out) | (~port_b_oe & (talk ? drive_word[15:8] : 8'hff));
  assign {port_b_handshake_in, general_sense_zero, port_a_handshake_in, general_sense_one} = flag_set;
endmodule

/* verification/parallel_port_address_select_test.sv */
`timescale 1ns/1ps
module parallel_port_address_select_test;
  import port_select_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  default_switch = 4'h0;
  logic [31:0] s_axi_awaddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [31:0] s_axi_araddr = '0;
  logic [31:0] s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  port_a_in, port_a_out, port_a_oe, port_b_in, port_b_out, port_b_oe;
  logic [7:0]  port_c_out, port_c_oe, port_d_out, port_d_oe;
  logic        port_a_handshake_out, port_a_handshake_in, port_b_handshake_out, port_b_handshake_in;
  logic        general_control_zero, general_sense_zero, general_control_one, general_sense_one;
  logic        port_a_direction_indicator, port_b_direction_indicator;
  logic [15:0] drive_word = 16'h0000;
  logic [3:0]  flag_set = 4'h0;
  logic [31:0] seed = 32'h000063e1;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          cur = 0;

  parallel_port_address_select DUT (.*);
  periph_model peer (.*);

  always #50 aclk = ~aclk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= {24'h0, a};
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [1:0] r;
    axi_wr(a, d, r);
    check({30'h0, r}, {30'h0, e});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    axi_rd(a, d, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic status(input logic given, input logic inp);
    logic [31:0] v;
    rd(OFS_STATUS, v);
    check({26'h0, v[9:8], v[3:0]}, {26'h0, given, inp, cur[3:0]});
  endtask

  task automatic do_reset(input logic [3:0] s);
    default_switch <= s;
    aresetn        <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  task automatic xfer(input logic inp, input logic pres, input logic [3:0] m, input logic [15:0] d);
    wr(OFS_XFER, {10'h0, inp, pres, m, d}, RESP_OKAY);
    if (pres) cur = {28'h0, m};
    repeat (4) @(posedge aclk);
  endtask

  task automatic pins(input logic [15:0] d);
    logic [7:0] la, lb, lc, ld, ea, eb, ec, ed;
    la = port_a_out | ~port_a_oe;
    lb = port_b_out | ~port_b_oe;
    lc = port_c_out | ~port_c_oe;
    ld = port_d_out | ~port_d_oe;
    // Tied pairs share one wire, so judge the wired level
    if (cur % 8 >= 6) begin
      la = la & lc;
      lc = la;
      lb = lb & ld;
      ld = lb;
    end
    {ea, eb, ec, ed} = 32'hffffffff;
    case (cur)
      0: ea = d[7:0];
      1: eb = d[7:0];
      2, 4: ec = d[7:0];
      3, 5: ed = d[7:0];
      6: {ea, ec} = {2{d[7:0]}};
      7: {eb, ed} = {2{d[7:0]}};
      8, 9: {ea, eb} = d[7:0] << 8 | d[15:8];
      14, 15: {ea, ec, eb, ed} = {{2{d[7:0]}}, {2{d[15:8]}}};
      default: {ec, ed} = {d[7:0], d[15:8]};
    endcase
    check({la, lb, lc, ld}, {ea, eb, ec, ed});
    check({30'h0, port_a_direction_indicator, port_b_direction_indicator},
          {30'h0, ((cur % 8) inside {4, 5}) ? 2'b11 : cur[0] ? 2'b10 : 2'b01});
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      $display("wrong value at %0t: run too long", $time);
      end_sim();
    end
  end

  initial begin
    logic [31:0] v;
    logic [1:0]  r;
    repeat (3) begin
      v = rnd();
      do_reset(v[3:0]);
      cur = {29'h0, v[2:0]};
      status(1'b0, 1'b0);
      rd(OFS_PRIMARY, v);
      check({28'h0, v[3:0]}, cur);
    end
    $display("test reset defaults done");
    for (int m = 0; m < 16; m++) begin
      v = rnd();
      xfer(1'b0, 1'b1, m[3:0], v[15:0]);
      pins(v[15:0]);
      status(1'b1, 1'b0);
    end
    v = rnd();
    xfer(1'b0, 1'b0, 4'h2, v[15:0]);
    pins(v[15:0]);
    wr(OFS_PRIMARY, 32'h3, RESP_OKAY);
    cur = 3;
    xfer(1'b0, 1'b0, 4'h9, v[31:16]);
    pins(v[31:16]);
    $display("test address selection done");
    for (int m = 0; m < 16; m += 8) begin
      v = rnd();
      drive_word <= v[15:0];
      repeat (4) @(posedge aclk);
      xfer(1'b1, 1'b1, m[3:0], 16'h0000);
      check({14'h0, port_a_direction_indicator, port_b_direction_indicator, port_a_oe, port_b_oe}, 32'h30000);
      rd(OFS_RXDATA, v);
      check(v & (m == 0 ? 32'hff : 32'hffff), {16'h0, drive_word} & (m == 0 ? 32'hff : 32'hffff));
      status(1'b1, 1'b1);
    end
    $display("test input done");
    // All control bits set, only the line owned by the address may show
    for (int i = 0; i < 4; i++) begin
      cur = (i / 2) * 4 + i % 2;
      wr(OFS_PRIMARY, cur, RESP_OKAY);
      wr(OFS_CTRL, 32'hf, RESP_OKAY);
      flag_set <= 4'h1 << i;
      repeat (4) @(posedge aclk);
      check({28'h0, general_control_one, general_control_zero, port_b_handshake_out, port_a_handshake_out},
            32'h1 << i);
      rd(OFS_STATUS, v);
      check({28'h0, v[7:4]}, 32'h1 << i);
    end
    $display("test handshake lines done");
    wr(8'h18, 32'h7, RESP_SLVERR);
    axi_rd(8'h10, v, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_rd(OFS_XFER, v, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    status(1'b1, 1'b1);
    do_reset(4'hd);
    cur = 5;
    status(1'b0, 1'b0);
    $display("test refusals and second reset done");
    end_sim();
  end
endmodule

bind parallel_port_address_select port_select_props chk (.*);
